// ### design/bgrf_pkg.sv
// Shared widths, indices and reset values of the banked register file.
package bgrf_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ARCH_W = 4;
    localparam int unsigned LOW_W = 3;
    localparam int unsigned PHYS_W = 5;
    localparam int unsigned PHYS_REGS = 24;
    localparam logic [PHYS_W-1:0] BANK0_BASE = 5'h00;
    localparam logic [PHYS_W-1:0] BANK1_BASE = 5'h08;
    localparam logic [PHYS_W-1:0] HIGH_BASE = 5'h10;
    localparam logic MODE_RESET = 1'h1;
    localparam logic BANK_RESET = 1'h1;
    localparam logic [DATA_W-1:0] OUT_RESET = 32'h0000_0000;
endpackage : bgrf_pkg

// ### design/bgrf_regfile.sv
// Banked general register file with mode and bank-select control.
`timescale 1ns/1ns

module bgrf_regfile
    import bgrf_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [ARCH_W-1:0] rdAddrA,
    input wire logic [ARCH_W-1:0] rdAddrB,
    input wire logic gpWrEn,
    input wire logic [ARCH_W-1:0] gpWrAddr,
    input wire logic [DATA_W-1:0] gpWrData,
    input wire logic ctlRdEn,
    input wire logic ctlWrEn,
    input wire logic [LOW_W-1:0] ctlIdx,
    input wire logic [DATA_W-1:0] ctlWrData,
    input wire logic statusWrEn,
    input wire logic modeIn,
    input wire logic bankIn,
    input wire logic excEntry,
    output logic [DATA_W-1:0] rdDataA_q,
    output logic [DATA_W-1:0] rdDataB_q,
    output logic [DATA_W-1:0] ctlRdData_q,
    output logic ctlFault_q,
    output logic modeBit_q,
    output logic bankBit_q
);

    logic [DATA_W-1:0] regs_q [PHYS_REGS];
    logic [DATA_W-1:0] regs_d [PHYS_REGS];
    logic [DATA_W-1:0] rdDataA_d;
    logic [DATA_W-1:0] rdDataB_d;
    logic [DATA_W-1:0] ctlRdData_d;
    logic ctlFault_d;
    logic modeBit_d;
    logic bankBit_d;

    // Physical index reached by an architectural name in the current mode.
    function automatic logic [PHYS_W-1:0] mapIdx(
        input logic [ARCH_W-1:0] a,
        input logic m,
        input logic b
    );
        logic [PHYS_W-1:0] low;
        low = {2'h0, a[LOW_W-1:0]};
        if (a[ARCH_W-1]) begin
            mapIdx = HIGH_BASE + low;
        end else if (m && b) begin
            mapIdx = BANK1_BASE + low;
        end else begin
            mapIdx = BANK0_BASE + low;
        end
    endfunction

    // Physical index of the low bank that is currently not mapped.
    function automatic logic [PHYS_W-1:0] otherIdx(
        input logic [LOW_W-1:0] i,
        input logic b
    );
        logic [PHYS_W-1:0] low;
        low = {2'h0, i};
        otherIdx = b ? (BANK0_BASE + low) : (BANK1_BASE + low);
    endfunction

    always_comb begin
        modeBit_d = modeBit_q;
        bankBit_d = bankBit_q;
        // Entry wins over a status write in the same cycle, since the
        // handler must always start on its own bank.
        if (excEntry) begin
            modeBit_d = 1'h1;
            bankBit_d = 1'h1;
        end else if (statusWrEn) begin
            modeBit_d = modeIn;
            bankBit_d = bankIn;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            modeBit_q <= MODE_RESET;
            bankBit_q <= BANK_RESET;
        end else begin
            modeBit_q <= modeBit_d;
            bankBit_q <= bankBit_d;
        end
    end

    always_comb begin
        regs_d = regs_q;
        // Writes use the mapping in force before any mode change this cycle.
        if (gpWrEn) begin
            regs_d[mapIdx(gpWrAddr, modeBit_q, bankBit_q)] = gpWrData;
        end
        // The control port only ever touches the unmapped bank, so it can
        // never collide with a general write in the same cycle.
        if (ctlWrEn && modeBit_q) begin
            regs_d[otherIdx(ctlIdx, bankBit_q)] = ctlWrData;
        end
    end

    // Contents have no reset; software must not rely on them after reset.
    always_ff @(posedge clock) begin
        regs_q <= regs_d;
    end

    always_comb begin
        rdDataA_d = regs_q[mapIdx(rdAddrA, modeBit_q, bankBit_q)];
        rdDataB_d = regs_q[mapIdx(rdAddrB, modeBit_q, bankBit_q)];
        ctlRdData_d = ctlRdData_q;
        if (ctlRdEn && modeBit_q) begin
            ctlRdData_d = regs_q[otherIdx(ctlIdx, bankBit_q)];
        end
        ctlFault_d = (ctlRdEn || ctlWrEn) && !modeBit_q;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rdDataA_q <= OUT_RESET;
            rdDataB_q <= OUT_RESET;
            ctlRdData_q <= OUT_RESET;
            ctlFault_q <= 1'h0;
        end else begin
            rdDataA_q <= rdDataA_d;
            rdDataB_q <= rdDataB_d;
            ctlRdData_q <= ctlRdData_d;
            ctlFault_q <= ctlFault_d;
        end
    end

    logic noWrites;
    assign noWrites = !gpWrEn && !ctlWrEn;

    sequence userLowWrite;
        gpWrEn && !modeBit_q && !gpWrAddr[ARCH_W-1] && !statusWrEn
            && !excEntry;
    endsequence

    sequence enterHandler;
        excEntry && noWrites;
    endsequence

    sequence ctlReadBack;
        ctlRdEn && noWrites && !statusWrEn && !excEntry
            && ctlIdx == $past(gpWrAddr[LOW_W-1:0], 2);
    endsequence

    reset_sets_bits_a: assert property (@(posedge clock)
        disable iff (!reset_n) $rose(reset_n) |-> modeBit_q && bankBit_q)
        else $error("Mode and bank bits not set after reset.");

    entry_switch_a: assert property (@(posedge clock)
        disable iff (!reset_n) excEntry |=> modeBit_q && bankBit_q)
        else $error("Exception entry did not select the handler bank.");

    status_mode_a: assert property (@(posedge clock)
        disable iff (!reset_n) statusWrEn && !excEntry
        |=> modeBit_q == $past(modeIn) && bankBit_q == $past(bankIn))
        else $error("Status write did not set mode and bank bits.");

    user_fault_a: assert property (@(posedge clock)
        disable iff (!reset_n) (ctlRdEn || ctlWrEn) && !modeBit_q
        |=> ctlFault_q && $stable(ctlRdData_q))
        else $error("User mode reached the unmapped bank.");

    priv_access_a: assert property (@(posedge clock)
        disable iff (!reset_n) (ctlRdEn || ctlWrEn) && modeBit_q
        |=> !ctlFault_q)
        else $error("Privileged control access was refused.");

    write_read_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        gpWrEn && !statusWrEn && !excEntry
        ##1 (rdAddrA == $past(gpWrAddr) && noWrites)
        |=> rdDataA_q == $past(gpWrData, 2))
        else $error("General read did not return the written value.");

    bank_zero_kept_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        userLowWrite ##1 enterHandler ##1 ctlReadBack
        |=> ctlRdData_q == $past(gpWrData, 3))
        else $error("User bank zero value lost across entry.");

    high_unbanked_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        gpWrEn && gpWrAddr[ARCH_W-1] && !statusWrEn && !excEntry
        ##1 (statusWrEn && noWrites)
        ##1 (rdAddrB == $past(gpWrAddr, 2) && noWrites)
        |=> rdDataB_q == $past(gpWrData, 3))
        else $error("High register changed with mode or bank.");

    bank_one_map_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        ctlWrEn && modeBit_q && !bankBit_q && !gpWrEn && !excEntry
        && !statusWrEn
        ##1 (statusWrEn && modeIn && bankIn && noWrites && !excEntry)
        ##1 (rdAddrA == {1'h0, $past(ctlIdx, 2)} && noWrites)
        |=> rdDataA_q == $past(ctlWrData, 3))
        else $error("Bank one not mapped with bank select set.");

    // A user value must still be seen after a move to privileged mode with
    // bank select clear, since both views share bank zero.
    user_priv_share_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        userLowWrite
        ##1 (statusWrEn && modeIn && !bankIn && noWrites && !excEntry)
        ##1 (rdAddrA == $past(gpWrAddr, 2) && noWrites)
        |=> rdDataA_q == $past(gpWrData, 3))
        else $error("Privileged bank zero differs from the user view.");

    user_bank_zero_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        ctlWrEn && modeBit_q && bankBit_q && !gpWrEn && !excEntry
        && !statusWrEn
        ##1 (statusWrEn && !modeIn && noWrites && !excEntry)
        ##1 (rdAddrA == {1'h0, $past(ctlIdx, 2)} && noWrites)
        |=> rdDataA_q == $past(ctlWrData, 3))
        else $error("User mode did not map the low names to bank zero.");

endmodule // bgrf_regfile

// ### testbench/bgrf_regfile_test.sv
// Random self-checking testbench for the banked general register file.
`timescale 1ns/1ns
module bgrf_regfile_test;
    import bgrf_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [ARCH_W-1:0] rdAddrA = '0, rdAddrB = '0, gpWrAddr = '0;
    logic [LOW_W-1:0] ctlIdx = '0;
    logic [DATA_W-1:0] gpWrData = '0, ctlWrData = '0;
    logic gpWrEn = 0, ctlRdEn = 0, ctlWrEn = 0, statusWrEn = 0;
    logic modeIn = 0, bankIn = 0, excEntry = 0;
    logic [DATA_W-1:0] rdDataA_q, rdDataB_q, ctlRdData_q;
    logic ctlFault_q, modeBit_q, bankBit_q;
    logic [DATA_W-1:0] mem [PHYS_REGS];
    bit known [PHYS_REGS];
    logic [DATA_W-1:0] eA, eB, eC, r;
    logic mM, mB, eF;
    bit kA, kB, kC;
    int seed = 98;
    int bad_count = 0;
    int samples_checked = 0;

    bgrf_regfile DUT (.clock(clock), .reset_n(reset_n), .rdAddrA(rdAddrA),
        .rdAddrB(rdAddrB), .gpWrEn(gpWrEn), .gpWrAddr(gpWrAddr),
        .gpWrData(gpWrData), .ctlRdEn(ctlRdEn), .ctlWrEn(ctlWrEn),
        .ctlIdx(ctlIdx), .ctlWrData(ctlWrData), .statusWrEn(statusWrEn),
        .modeIn(modeIn), .bankIn(bankIn), .excEntry(excEntry),
        .rdDataA_q(rdDataA_q), .rdDataB_q(rdDataB_q),
        .ctlRdData_q(ctlRdData_q), .ctlFault_q(ctlFault_q),
        .modeBit_q(modeBit_q), .bankBit_q(bankBit_q));

    always #5 clock = ~clock;

    function automatic int phys(logic [ARCH_W-1:0] a, logic m, logic b);
        if (a[3]) return int'(HIGH_BASE) + int'(a[2:0]);
        if (m && b) return int'(BANK1_BASE) + int'(a[2:0]);
        return int'(BANK0_BASE) + int'(a[2:0]);
    endfunction

    task automatic check(input logic [DATA_W-1:0] seen,
        input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Works out the next edge's outputs from the inputs now settled.
    task automatic predict;
        int w, c, pA, pB;
        w = phys(gpWrAddr, mM, mB);
        c = int'(mB ? BANK0_BASE : BANK1_BASE) + int'(ctlIdx);
        pA = phys(rdAddrA, mM, mB);
        pB = phys(rdAddrB, mM, mB);
        // The array has no reset, so it still takes writes while reset is
        // held; only the flops of the outputs and of mode and bank reset.
        {eA, kA, eB, kB} = {mem[pA], known[pA], mem[pB], known[pB]};
        eF = (ctlRdEn | ctlWrEn) & !mM;
        if (ctlRdEn && mM) {eC, kC} = {mem[c], known[c]};
        if (gpWrEn) {mem[w], known[w]} = {gpWrData, 1'h1};
        if (ctlWrEn && mM) {mem[c], known[c]} = {ctlWrData, 1'h1};
        if (excEntry) {mM, mB} = 2'h3;
        else if (statusWrEn) {mM, mB} = {modeIn, bankIn};
        if (!reset_n) begin
            eA = OUT_RESET;
            eB = OUT_RESET;
            eC = OUT_RESET;
            {kA, kB, kC, eF, mM, mB} = {3'h7, 1'h0, MODE_RESET, BANK_RESET};
        end
    endtask

    task automatic drive(input int i);
        bit corner;
        corner = (i % 97 == 5);
        r = $random(seed);
        reset_n <= !(i < 1 || i == 1500 || i == 1501);
        rdAddrA <= (i % 7 == 0) ? gpWrAddr : r[3:0];
        rdAddrB <= r[7:4];
        gpWrAddr <= r[11:8];
        ctlIdx <= r[14:12];
        gpWrEn <= r[15] | r[16];
        ctlRdEn <= r[17];
        ctlWrEn <= r[18] & r[19];
        // Entry and a user-mode status write land together now and then.
        statusWrEn <= (r[20] & r[21]) | corner;
        modeIn <= r[22] & !corner;
        bankIn <= r[23];
        excEntry <= (&r[27:24]) | corner;
        gpWrData <= $random(seed);
        ctlWrData <= $random(seed);
    endtask

    initial begin
        #1 predict();
        for (int i = 0; i < 3000; i++) begin
            @(posedge clock);
            drive(i);
            #1;
            if (kA) check(rdDataA_q, eA);
            if (kB) check(rdDataB_q, eB);
            if (kC) check(ctlRdData_q, eC);
            check({31'h0, ctlFault_q}, {31'h0, eF});
            check({31'h0, modeBit_q}, {31'h0, mM});
            check({31'h0, bankBit_q}, {31'h0, mB});
            predict();
        end
        give_verdict();
    end

    // The main loop takes about 30,000 ns; a third more is the limit.
    initial begin
        #40000;
        bad_count++;
        give_verdict();
    end
endmodule // bgrf_regfile_test
